//--- count_scaler.sv
// signed ratio scaling of four-edge encoder counts
`timescale 1ns/100ps
`include "enc_phasing_consts.svh"
module count_scaler #(
	parameter int W = 16
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                edge_pulse,
	input  wire logic                edge_dir,
	input  wire logic signed [W-1:0] numerator,
	input  wire logic signed [W-1:0] denominator,
	output logic signed [31:0]       position
);
	logic signed [31:0] acc_q;
	logic signed [31:0] pos_q;
	logic signed [31:0] step;
	logic signed [31:0] den_abs;
	logic signed [31:0] acc_next;

	// negative ratio flips the count direction
	always_comb begin
		den_abs  = (denominator < 0) ? -32'(denominator) : 32'(denominator);
		step     = (edge_dir ^ (denominator < 0)) ? -32'(numerator) : 32'(numerator);
		acc_next = acc_q + step;
	end

	// remainder carried so no fractional count is ever lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= 32'sh0;
			pos_q <= 32'sh0;
		end else if (edge_pulse && den_abs != 0) begin
			if (acc_next >= den_abs) begin
				acc_q <= acc_next - den_abs;
				pos_q <= pos_q + 32'sh1;
			end else if (acc_next <= -den_abs) begin
				acc_q <= acc_next + den_abs;
				pos_q <= pos_q - 32'sh1;
			end else begin
				acc_q <= acc_next;
			end
		end
	end

	assign position = pos_q;

	a_scale_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!edge_pulse |=> $stable(pos_q))
		else $error("position moved without an encoder edge");
endmodule // count_scaler

//--- enc_phasing.sv
// encoder feedback selection and rotor phasing sequencer with apb registers
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`include "enc_phasing_consts.svh"
module enc_phasing #(
	parameter int MOVE_CYC = `MOVE_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        enc_a,
	input  wire logic        enc_b,
	input  wire logic        enc_zero,
	input  wire logic        hardware_enable_status,
	input  wire logic        inrush_closed,
	input  wire logic [15:0] alarm_code,
	input  wire logic        drive_ready,
	output enc_phasing_pkg::excite_t excite,
	output logic             encoder_feedback_active,
	output logic             zero_is_home_ref,
	output logic             drive_ok_flag,
	output logic             phasing_result_flag,
	output logic             irq
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {enc_zero, enc_b, enc_a};
			sync2_q <= sync1_q;
		end
	end

	// quadrature decode, every edge of a or b counts unless both tracks change in the same cycle
	logic [1:0] ab_q;
	logic       edge_pulse;
	logic       edge_dir;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ab_q <= 2'h0;
		else
			ab_q <= sync2_q[1:0];
	end
	assign edge_pulse = (ab_q != sync2_q[1:0]) && (ab_q != ~sync2_q[1:0]);
	assign edge_dir   = ab_q[0] ^ sync2_q[1];

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic               fbk_sel_q;
	logic               fbk_live_q;
	logic               ph1_cmd_q;
	logic               ph2_cmd_q;
	logic               sw_enable_q;
	logic               freq_saved_q;
	logic signed [15:0] num_q;
	logic signed [15:0] den_q;
	logic [15:0]        status_code_q;
	logic [15:0]        freq_q;
	logic [15:0]        poles_q;
	logic [2:0]         irq_stat_q;
	logic [2:0]         irq_mask_q;
	logic               result_q;
	logic               finish;
	logic [15:0]        finish_code;
	logic               restart_q;
	logic signed [31:0] position;

	wire wr_en = psel && penable && pwrite;
	wire rd_en = psel && penable && !pwrite;
	wire mapped = (paddr <= `OFS_POSITION) && (paddr[1:0] == 2'h0);

	// only the low 16 bits are kept on write, and -32768 is clipped to -32767
	function automatic logic signed [15:0] clip(input logic [31:0] v);
		logic signed [15:0] s;
		s = v[15:0];
		if (s == 16'sh8000)
			clip = -`RATIO_LIMIT;
		else
			clip = s;
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fbk_sel_q    <= 1'b0;
			ph1_cmd_q    <= 1'b0;
			ph2_cmd_q    <= 1'b0;
			sw_enable_q  <= 1'b0;
			freq_saved_q <= 1'b0;
			num_q        <= `RATIO_RESET;
			den_q        <= `RATIO_RESET;
			poles_q      <= `POLES_RESET;
			irq_mask_q   <= 3'h0;
		end else begin
			if (finish) begin
				ph1_cmd_q <= 1'b0;
				ph2_cmd_q <= 1'b0;
			end
			if (wr_en) begin
				unique case (paddr)
					`OFS_CONTROL: begin
						fbk_sel_q    <= pwdata[`CTL_FBK_SEL];
						sw_enable_q  <= pwdata[`CTL_SW_ENABLE];
						freq_saved_q <= pwdata[`CTL_FREQ_SAVED];
						if (!finish && !ph1_cmd_q && !ph2_cmd_q) begin
							ph1_cmd_q <= pwdata[`CTL_PH1_CMD];
							ph2_cmd_q <= pwdata[`CTL_PH2_CMD] && !pwdata[`CTL_PH1_CMD];
						end
					end
					`OFS_NUMERATOR:   num_q      <= clip(pwdata);
					`OFS_DENOMINATOR: den_q      <= clip(pwdata);
					`OFS_POLE_COUNT:  poles_q    <= pwdata[15:0];
					`OFS_IRQ_MASK:    irq_mask_q <= pwdata[2:0];
					default: ;
				endcase
			end
		end
	end

	// the select bit is latched into use only by a drive restart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restart_q  <= 1'b0;
			fbk_live_q <= 1'b0;
		end else begin
			restart_q <= drive_ready;
			if (drive_ready && !restart_q)
				fbk_live_q <= fbk_sel_q;
		end
	end
	assign encoder_feedback_active = fbk_live_q;
	assign zero_is_home_ref        = !fbk_live_q;

	// ----------------------------------------------------------------
	// phasing sequencer
	// ----------------------------------------------------------------
	enc_phasing_pkg::phase_state_t state_q;
	logic [31:0]        timer_q;
	logic signed [31:0] start_pos_q;
	logic [15:0]        vib_freq_q;
	logic [15:0]        vib_start_q;
	logic               proc2_q;
	logic               second_q;
	wire  enables_ok = !sw_enable_q && hardware_enable_status;
	wire  drive_rdy  = (alarm_code == 16'h0) && inrush_closed;
	wire  timer_done = (timer_q == 32'(MOVE_CYC - 1));
	wire signed [31:0] moved = position - start_pos_q;
	wire signed [31:0] expect_ticks = (`QUARTER_ELEC / 32'(poles_q >> 1));
	wire signed [31:0] tol_ticks    = (`POLE_TOL_ELEC / 32'(poles_q >> 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q     <= enc_phasing_pkg::PH_IDLE;
			timer_q     <= 32'h0;
			start_pos_q <= 32'sh0;
			proc2_q     <= 1'b0;
			second_q    <= 1'b0;
			vib_freq_q  <= `FREQ_RESET;
			vib_start_q <= `FREQ_RESET;
			finish      <= 1'b0;
			finish_code <= `ST_OK;
		end else begin
			finish <= 1'b0;
			unique case (state_q)
				enc_phasing_pkg::PH_IDLE: if ((ph1_cmd_q || ph2_cmd_q) && !finish) begin
					proc2_q <= ph2_cmd_q;
					state_q <= enc_phasing_pkg::PH_CHECK;
				end
				enc_phasing_pkg::PH_CHECK: begin
					timer_q     <= 32'h0;
					start_pos_q <= position;
					second_q    <= 1'b0;
					vib_start_q <= vib_freq_q;
					if (!drive_rdy) begin
						finish_code <= `ST_NOT_READY;
						state_q     <= enc_phasing_pkg::PH_DONE;
					end else if (!enables_ok) begin
						finish_code <= `ST_BAD_ENABLE;
						state_q     <= enc_phasing_pkg::PH_DONE;
					end else if (proc2_q)
						state_q <= enc_phasing_pkg::PH_VIBRATE;
					else
						state_q <= enc_phasing_pkg::PH_MOVE_A;
				end
				enc_phasing_pkg::PH_MOVE_A: begin
					timer_q <= timer_done ? 32'h0 : timer_q + 32'h1;
					if (timer_done) begin
						start_pos_q <= position;
						state_q     <= enc_phasing_pkg::PH_MOVE_B;
					end
				end
				enc_phasing_pkg::PH_MOVE_B: begin
					timer_q <= timer_done ? 32'h0 : timer_q + 32'h1;
					if (timer_done)
						state_q <= enc_phasing_pkg::PH_JUDGE;
				end
				enc_phasing_pkg::PH_VIBRATE: begin
					timer_q <= timer_done ? 32'h0 : timer_q + 32'h1;
					if (timer_done) begin
						// a seeded start needs only one vibration
						if (freq_saved_q || second_q)
							state_q <= enc_phasing_pkg::PH_JUDGE;
						second_q   <= 1'b1;
						vib_freq_q <= 16'((moved < 0 ? -moved : moved) & 32'h0000_FFFF);
					end
				end
				enc_phasing_pkg::PH_JUDGE: begin
					state_q <= enc_phasing_pkg::PH_DONE;
					if (proc2_q) begin
						if (vib_freq_q > `FREQ_MAX_UNITS)
							finish_code <= `ST_FREQ_MAX;
						else if ((vib_freq_q > vib_start_q ? vib_freq_q - vib_start_q
							: vib_start_q - vib_freq_q) >= `FREQ_DRIFT_UNITS)
							finish_code <= `ST_FREQ_DRIFT;
						else
							finish_code <= `ST_OK;
					end else if (moved <= 0)
						finish_code <= `ST_POS_FBK;
					else if (moved > expect_ticks + tol_ticks || moved < expect_ticks - tol_ticks)
						finish_code <= `ST_BAD_POLES;
					else
						finish_code <= `ST_OK;
				end
				enc_phasing_pkg::PH_DONE: begin
					finish  <= 1'b1;
					state_q <= enc_phasing_pkg::PH_IDLE;
				end
			endcase
		end
	end

	// drive output: a positive step per move, alternating during vibration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			excite <= '0;
		else begin
			excite.active  <= (state_q == enc_phasing_pkg::PH_MOVE_A) ||
				(state_q == enc_phasing_pkg::PH_MOVE_B) || (state_q == enc_phasing_pkg::PH_VIBRATE);
			excite.vibrate <= (state_q == enc_phasing_pkg::PH_VIBRATE);
			excite.level   <= (state_q == enc_phasing_pkg::PH_VIBRATE && timer_q[4]) ?
				-16'sh0400 : 16'sh0400;
		end
	end

	// status code and result flag written together when a procedure ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_code_q <= `ST_OK;
			result_q      <= 1'b0;
			freq_q        <= `FREQ_RESET;
		end else if (finish) begin
			status_code_q <= finish_code;
			result_q      <= (finish_code == `ST_OK);
			if (proc2_q)
				freq_q <= vib_freq_q;
		end
	end
	assign phasing_result_flag = result_q;
	// without a good result the drive never reports ok
	assign drive_ok_flag = result_q && drive_ready && drive_rdy;

	// ----------------------------------------------------------------
	// interrupts: done, failure, feedback change pending
	// ----------------------------------------------------------------
	wire [2:0] irq_ev = {fbk_sel_q != fbk_live_q, finish && finish_code != `ST_OK, finish};
	wire       irq_rd = rd_en && paddr == `OFS_IRQ_STATUS;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_stat_q <= 3'h0;
		else
			irq_stat_q <= (irq_rd ? 3'h0 : irq_stat_q) | irq_ev;
	end
	assign irq = |(irq_stat_q & irq_mask_q);

	// ----------------------------------------------------------------
	// apb read side, zero wait states
	// ----------------------------------------------------------------
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				`OFS_CONTROL:     prdata <= {27'h0, freq_saved_q, sw_enable_q,
					ph2_cmd_q, ph1_cmd_q, fbk_sel_q};
				`OFS_STATUS_BITS: prdata <= {29'h0, fbk_live_q, result_q, drive_ok_flag};
				`OFS_NUMERATOR:   prdata <= {16'h0, num_q};
				`OFS_DENOMINATOR: prdata <= {16'h0, den_q};
				`OFS_STATUS_CODE: prdata <= {16'h0, status_code_q};
				`OFS_VIB_FREQ:    prdata <= {16'h0, freq_q};
				`OFS_POLE_COUNT:  prdata <= {16'h0, poles_q};
				`OFS_IRQ_STATUS:  prdata <= {29'h0, irq_stat_q};
				`OFS_IRQ_MASK:    prdata <= {29'h0, irq_mask_q};
				`OFS_POSITION:    prdata <= position;
				default:          prdata <= 32'h0;
			endcase
		end
	end

	count_scaler #(.W(16)) u_scaler (
		.pclk       (pclk),
		.presetn    (presetn),
		.edge_pulse (edge_pulse),
		.edge_dir   (edge_dir),
		.numerator  (num_q),
		.denominator(den_q),
		.position   (position)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_finish_fail;
		finish && finish_code != `ST_OK;
	endsequence
	a_fail_no_ok: assert property (@(posedge pclk) disable iff (!presetn)
		s_finish_fail |=> !phasing_result_flag && !drive_ok_flag)
		else $error("drive ok after failed phasing");
	a_ok_needs_result: assert property (@(posedge pclk) disable iff (!presetn)
		drive_ok_flag |-> phasing_result_flag)
		else $error("drive ok without phasing result");
	a_cmd_cleared: assert property (@(posedge pclk) disable iff (!presetn)
		finish |=> !ph1_cmd_q && !ph2_cmd_q)
		else $error("command not cleared at finish");
	a_code_written: assert property (@(posedge pclk) disable iff (!presetn)
		finish |=> status_code_q == $past(finish_code))
		else $error("status code not written at finish");
	a_not_ready_code: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == enc_phasing_pkg::PH_CHECK && !drive_rdy |=> ##1 finish_code == `ST_NOT_READY)
		else $error("not ready not reported");
	a_fbk_restart: assert property (@(posedge pclk) disable iff (!presetn)
		!(drive_ready && !restart_q) |=> $stable(fbk_live_q))
		else $error("feedback select changed without restart");
	a_two_moves: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == enc_phasing_pkg::PH_MOVE_B |-> $past(state_q) inside
		{enc_phasing_pkg::PH_MOVE_A, enc_phasing_pkg::PH_MOVE_B})
		else $error("second move without first");
	a_freq_max: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == enc_phasing_pkg::PH_JUDGE && proc2_q && vib_freq_q > `FREQ_MAX_UNITS
		|=> finish_code == `ST_FREQ_MAX)
		else $error("frequency over maximum not reported");
endmodule // enc_phasing

//--- enc_phasing_consts.svh
// constants for the encoder feedback phasing sequencer
//
// Functional notes
// - encoder feedback used when select bit set; restart applies
// - procedure one: two moves, last 90 deg, sign check
// - counts scaled by signed ratio, operands within 32767
// - procedure one codes 0, 2, 3, 4
// - status 5 when alarm or inrush open
// - failed phasing keeps drive ok low
// - result flag set only on success, gates drive ok
// - procedure two excites a vibration instead
// - procedure two codes 6 and 7 on frequency
// - saved frequency seeds next start, one vibration
// - command, select, ok and result bits reset zero
// - zero track never used as machine reset reference; here it is, while encoder feedback is inactive
`ifndef ENC_PHASING_CONSTS_SVH
`define ENC_PHASING_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL      12'h000
`define OFS_STATUS_BITS  12'h004
`define OFS_NUMERATOR    12'h008
`define OFS_DENOMINATOR  12'h00C
`define OFS_STATUS_CODE  12'h010
`define OFS_VIB_FREQ     12'h014
`define OFS_POLE_COUNT   12'h018
`define OFS_IRQ_STATUS   12'h01C
`define OFS_IRQ_MASK     12'h020
`define OFS_POSITION     12'h024

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define CTL_FBK_SEL      0
`define CTL_PH1_CMD      1
`define CTL_PH2_CMD      2
`define CTL_SW_ENABLE    3
`define CTL_FREQ_SAVED   4

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define RATIO_RESET      16'h0001
`define RATIO_LIMIT      16'sh7FFF
`define POLES_RESET      16'h0004
`define POS_FULL_TURN    32'h0001_0000
`define ST_OK            16'h0000
`define ST_BAD_ENABLE    16'h0002
`define ST_POS_FBK       16'h0003
`define ST_BAD_POLES     16'h0004
`define ST_NOT_READY     16'h0005
`define ST_FREQ_DRIFT    16'h0006
`define ST_FREQ_MAX      16'h0007
`define FREQ_DRIFT_UNITS 16'h0019
`define FREQ_MAX_UNITS   16'h00C8
`define FREQ_RESET       16'h0032
// 22.5 electrical degrees, in 1/65536 turn of electrical angle
`define POLE_TOL_ELEC    32'h0000_1000
`define QUARTER_ELEC     32'h0000_4000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    20
`define MOVE_TIME_US     100
`define MOVE_CYCLES      ((`MOVE_TIME_US * 1000) / `CLK_PERIOD_NS)

`endif

//--- enc_phasing_pkg.sv
// types for the encoder feedback phasing sequencer
package enc_phasing_pkg;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_CHECK,
		PH_MOVE_A,
		PH_MOVE_B,
		PH_VIBRATE,
		PH_JUDGE,
		PH_DONE
	} phase_state_t;

	typedef struct packed {
		logic        active;
		logic signed [15:0] level;
		logic        vibrate;
	} excite_t;

	typedef struct packed {
		logic        sw_enable;
		logic        hw_enable;
		logic        inrush_closed;
		logic [15:0] alarm;
	} drive_cond_t;

endpackage

//--- motor_model.sv
// servo motor with quadrature encoder, driven by the phasing excitation
`timescale 1ns/100ps
module motor_model (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  enc_phasing_pkg::excite_t excite,
	input  wire logic                stall,
	input  wire logic                reverse,
	output logic                     enc_a,
	output logic                     enc_b,
	output logic                     enc_zero
);
	logic [1:0] div_q;
	logic [7:0] pos_q;
	logic [3:0] swing_q;

	// ----------------------------------------------------------------
	// shaft motion
	// ----------------------------------------------------------------
	// a stalled rotor gives no edges at all, which is what a blocked shaft does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q   <= 2'h0;
			pos_q   <= 8'h00;
			swing_q <= 4'h0;
		end else if (excite.active && !stall && excite.level != 16'sh0000) begin
			div_q <= div_q + 2'h1;
			if (div_q == 2'h3) begin
				swing_q <= swing_q + 4'h1;
				if ((excite.level[15] ^ reverse) ^ (excite.vibrate & swing_q[3]))
					pos_q <= pos_q - 8'h01;
				else
					pos_q <= pos_q + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// encoder tracks
	// ----------------------------------------------------------------
	// a leads b while the shaft turns forward, so forward counts up
	assign enc_a    = pos_q[1] ^ pos_q[0];
	assign enc_b    = pos_q[1];
	assign enc_zero = (pos_q[7:2] == 6'h00);
endmodule // motor_model

//--- test_encoder_feedback_phasing.sv
// self-checking bench for the phasing sequencer with its motor
`timescale 1ns/100ps
`include "enc_phasing_consts.svh"
module test_encoder_feedback_phasing;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        enc_a;
	logic        enc_b;
	logic        enc_zero;
	logic        hw_en = 1'b1;
	logic        inrush = 1'b1;
	logic [15:0] alarm = 16'h0000;
	logic        drive_ready = 1'b1;
	logic        stall = 1'b0;
	enc_phasing_pkg::excite_t excite;
	logic        fbk_act;
	logic        zero_ref;
	logic        drive_ok;
	logic        result;
	logic        irq;
	int          miscompares = 0;
	int          num_checks = 0;
	int          act_n = 0;
	int          vib_n = 0;
	int          seed = 34267;
	logic [31:0] rd;
	logic        err;
	logic        saved = 1'b0;
	localparam int MOVE_CYC = 8;

	enc_phasing #(.MOVE_CYC(MOVE_CYC)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .enc_zero(enc_zero),
		.hardware_enable_status(hw_en), .inrush_closed(inrush), .alarm_code(alarm),
		.drive_ready(drive_ready), .excite(excite), .encoder_feedback_active(fbk_act),
		.zero_is_home_ref(zero_ref), .drive_ok_flag(drive_ok), .phasing_result_flag(result),
		.irq(irq));
	motor_model u_motor (.pclk(pclk), .presetn(presetn), .excite(excite), .stall(stall),
		.reverse(1'b0), .enc_a(enc_a), .enc_b(enc_b), .enc_zero(enc_zero));

	initial begin
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (excite.active === 1'b1) begin
			act_n++;
			if (excite.vibrate === 1'b1)
				vib_n++;
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// an idle cycle after each transfer keeps drivers from double assignment
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [15:0] exp_code(logic ph2, logic sw, logic hw, logic al,
		logic inr, logic stl, logic [15:0] ok_code);
		if (al || !inr)
			return `ST_NOT_READY;
		if (sw || !hw)
			return `ST_BAD_ENABLE;
		if (stl)
			return ph2 ? `ST_FREQ_DRIFT : `ST_POS_FBK;
		return ok_code;
	endfunction

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] v;
		logic [15:0] e;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("result flag", 0, result);
		chk("drive ok", 0, drive_ok);
		chk("irq", 0, irq);
		apb(0, `OFS_CONTROL, 0);
		chk("control", 0, rd);
		apb(0, `OFS_NUMERATOR, 0);
		chk("numerator", 1, rd[15:0]);
		apb(0, `OFS_DENOMINATOR, 0);
		chk("denominator", 1, rd[15:0]);
		apb(0, `OFS_VIB_FREQ, 0);
		chk("vib freq", `FREQ_RESET, rd[15:0]);
		apb(1, 12'h030, 32'h5A5A);
		apb(0, 12'h030, 0);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, rd);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7FFF : $random(seed);
			e = (v == 16'h8000) ? 16'h8001 : v;
			apb(1, (i % 2) ? `OFS_DENOMINATOR : `OFS_NUMERATOR, {16'h0, v});
			apb(0, (i % 2) ? `OFS_DENOMINATOR : `OFS_NUMERATOR, 0);
			chk("ratio", e, rd[15:0]);
		end
		apb(1, `OFS_NUMERATOR, 1);
		apb(1, `OFS_DENOMINATOR, 1);
		apb(1, `OFS_CONTROL, 1);
		chk("fbk before restart", 0, fbk_act);
		drive_ready <= 1'b0;
		repeat (3) @(posedge pclk);
		drive_ready <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("fbk after restart", 1, fbk_act);
		chk("zero ref", 0, zero_ref);
		apb(1, `OFS_IRQ_MASK, 32'h7);
		apb(0, `OFS_IRQ_STATUS, 0);
		// case bits: sw, hw low, alarm, inrush open, stall, procedure two
		// a clean move makes three counts, far short of a quarter turn at 4 poles
		for (int i = 0; i < 8; i++) begin
			run_case((8'b00110100 >> i) & 1, (8'b00000001 >> i) & 1,
				!((8'b00100000 >> i) & 1), (8'b10000010 >> i) & 1,
				!((8'b00000100 >> i) & 1), (8'b00011000 >> i) & 1, `ST_BAD_POLES);
		end
		// quarter electrical turn of 4 counts, tolerance 1: three counts pass
		apb(1, `OFS_POLE_COUNT, 32'h2000);
		run_case(0, 0, 1, 0, 1, 0, `ST_OK);
		// saved estimate of zero is the start; one short vibration keeps it
		saved = 1'b1;
		run_case(1, 0, 1, 0, 1, 0, `ST_OK);
		finish_test();
	end

	// sets hardware enable, inrush, alarm and stall for the case before commanding
	task automatic run_case(logic ph2, logic sw, logic hw, logic al, logic inr, logic stl,
		logic [15:0] ok_code);
		logic [15:0] e;
		int n;
		e = exp_code(ph2, sw, hw, al, inr, stl, ok_code);
		hw_en <= hw;
		inrush <= inr;
		alarm <= al ? 16'h0003 : 16'h0000;
		stall <= stl;
		@(posedge pclk);
		act_n = 0;
		vib_n = 0;
		apb(1, `OFS_CONTROL, {27'h0, saved, sw, ph2, !ph2, 1'b1});
		n = 0;
		do begin
			apb(0, `OFS_CONTROL, 0);
			n++;
		end while (rd[2:1] !== 2'b00 && n < 60);
		if (n >= 60) begin
			miscompares++;
			finish_test();
		end
		chk("cmd cleared", 0, rd[2:1]);
		apb(0, `OFS_STATUS_CODE, 0);
		chk("status code", e, rd[15:0]);
		chk("result flag", e == `ST_OK, result);
		chk("drive ok", e == `ST_OK, drive_ok);
		if (!al && inr && !sw && hw) begin
			chk("excited", 1, act_n > 0);
			chk("vibrating", ph2, vib_n > 0);
			if (saved && ph2)
				chk("one vibration", MOVE_CYC, vib_n);
		end
		chk("irq raised", 1, irq);
		apb(0, `OFS_IRQ_STATUS, 0);
		chk("irq cause", {e != `ST_OK, 1'b1}, rd[1:0]);
		chk("irq cleared", 0, irq);
	endtask

	initial begin
		repeat (100000) @(posedge pclk);
		miscompares++;
		finish_test();
	end
endmodule // test_encoder_feedback_phasing
